// ==== shared/pac_regs.svh ====
`ifndef PAC_REGS_SVH
`define PAC_REGS_SVH
// Summary of operation
// - component counter cycles red, green, blue
// - upper address: table entries or overlays 1-3
// - select clear: data write loads entry address
// - blue write stores entry, increments address
// - table reads red, green, blue; else address
// - cursor selects: low, high, RAM, control
// - two address bytes form sixteen-bit pointer
// - RAM access bumps low nine; 0x1ff clears whole pointer
// - pointer low nibble picks control register
// - control access bumps; 0x1ff clears whole pointer only on write
// - address register access does not increment
// - command register always readable and writable
// - multiplex field stored; software programs 1:1
// - pattern bit one selects overlay colour 1, unless XOR with hair
// - pattern column 31 sits at cursor x
// - horizontal count starts after strobe rise
// - lines start at hdrive fall two clocks later
// - cross hair centred on cursor position
// - line control bit zero drives strobe, resets

// ------------------------------------------------------------
// target select codes {high, low}
// ------------------------------------------------------------
`define PAC_SEL_ADDR_LOW 2'h0
`define PAC_SEL_ADDR_HIGH 2'h1
`define PAC_SEL_RAM 2'h2
`define PAC_SEL_CTRL 2'h3

// ------------------------------------------------------------
// palette component codes
// ------------------------------------------------------------
`define PAC_COMP_RED 2'h0
`define PAC_COMP_GREEN 2'h1
`define PAC_COMP_BLUE 2'h2
`define PAC_OVL_FIRST 8'h01
`define PAC_OVL_LAST 8'h03

// ------------------------------------------------------------
// cursor pointer and control register indexes
// ------------------------------------------------------------
`define PAC_PTR_BURST_END 9'h1ff
`define PAC_CTRL_CMD 4'h0
`define PAC_CTRL_LAST 4'hc
`define PAC_CTRL_CX 4'h1
`define PAC_CTRL_CY 4'h3
`define PAC_CTRL_WX 4'h5
`define PAC_CTRL_WY 4'h7
`define PAC_CTRL_WW 4'h9
`define PAC_CTRL_WH 4'hb

// ------------------------------------------------------------
// command register fields
// ------------------------------------------------------------
`define PAC_CMD_PAT_EN 6
`define PAC_CMD_HAIR_EN 5
`define PAC_CMD_OR_MODE 4
`define PAC_CMD_RESET 8'h00

// ------------------------------------------------------------
// pattern geometry and pin sync slots
// ------------------------------------------------------------
`define PAC_PAT_CENTRE 14'sd31
`define PAC_PAT_LAST 14'sd63
`define PAC_VARM_MIN 2'h2
`define PAC_PIN_PIXCLK 0
`define PAC_PIN_HSTROBE 1
`define PAC_PIN_VSTROBE 2
`define PAC_PIN_HDRIVE 3
`endif

// ==== shared/pac_pkg.sv ====
package pac_pkg;
  // all register state of the access block
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pinLevel;
    logic palRdPrevN;
    logic palWrPrevN;
    logic curRdPrevN;
    logic curWrPrevN;
    logic [7:0] entryAddr;
    logic [1:0] compCount;
    logic [7:0] redHold;
    logic [7:0] greenHold;
    logic [7:0] palRdData;
    logic [15:0] curPtr;
    logic [7:0] curCommand;
    logic [11:0][7:0] posRegs;
    logic [7:0] curRdData;
    logic [11:0] hCount;
    logic [11:0] vCount;
    logic [1:0] vArm;
    logic vWait;
    logic hStrobe;
    logic overlayActive;
    logic [23:0] pixelRgb;
  } pac_state_s;
endpackage

// ==== src/pac_access_top.sv ====
`timescale 1ns/1ps
`include "pac_regs.svh"

module pac_access_top
  import pac_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic targetSelectLow, // select bit 8
  input wire logic targetSelectHigh, // select bit 9
  input wire logic paletteRdN,
  input wire logic paletteWrN,
  input wire logic [7:0] paletteWrData,
  output logic [7:0] paletteRdData,
  input wire logic cursorRdN,
  input wire logic cursorWrN,
  input wire logic [7:0] cursorWrData,
  output logic [7:0] cursorRdData,
  input wire logic pixelClock, // pin, sampled
  input wire logic lineControlBit0, // pin, sampled
  input wire logic verticalCursorStrobeN, // pin, sampled
  input wire logic horizontalDrive, // pin, sampled
  input wire logic [7:0] pixelIndex, // image pixel, core domain
  output logic horizontalCursorStrobe,
  output logic overlayActive,
  output logic [23:0] pixelRgb
);

  // ------------------------------------------------------------
  // storage arrays
  // ------------------------------------------------------------
  logic [23:0] lutMem [0:255]; // colour lookup table
  logic [23:0] overlayMem [0:2]; // overlay colours 1..3
  logic [7:0] patternMem [0:511]; // 64x64 pattern bits
  // arrays hold no reset: contents stay unknown until loaded

  // ------------------------------------------------------------
  // state and next state
  // ------------------------------------------------------------
  pac_state_s s_q; // registered state
  pac_state_s s_d; // next state

  // memory write requests from the access logic
  logic lutWe;
  logic ovlWe;
  logic patWe;
  logic [7:0] lutWaddr;
  logic [1:0] ovlWaddr;
  logic [8:0] patWaddr;
  logic [23:0] colourWdata;
  logic [7:0] patWdata;

  // helpers for the comb process
  logic [1:0] sel; // {high, low} selects
  logic palRdTake; // palette read taken
  logic palWrTake; // palette write taken
  logic curRdTake; // cursor read taken
  logic curWrTake; // cursor write taken
  logic [3:0] pinNow; // filtered pin levels
  logic pixRise; // pixel clock rising
  logic hdriveFall; // horizontal drive falling
  logic vstrobeFall; // vertical strobe falling
  logic [23:0] entryColour; // colour at current entry
  logic [7:0] compByte; // selected component
  logic [7:0] ctrlByte; // selected control byte
  logic [11:0] cx, cy, wx, wy, ww, wh; // cursor geometry
  logic signed [13:0] dx, dy, col, row; // offsets
  logic signed [13:0] half; // half thickness
  logic patIn; // inside pattern square
  logic [7:0] patByte; // pattern byte under beam
  logic patBit; // pattern pixel
  logic hairBit; // cross hair pixel
  logic inWin; // inside cross hair window
  logic cursorOn; // combined cursor pixel

  // ------------------------------------------------------------
  // next state logic
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    lutWe = 1'b0;
    ovlWe = 1'b0;
    patWe = 1'b0;
    lutWaddr = s_q.entryAddr;
    ovlWaddr = 2'(s_q.entryAddr - `PAC_OVL_FIRST);
    patWaddr = s_q.curPtr[8:0];
    colourWdata = {s_q.redHold, s_q.greenHold, paletteWrData};
    patWdata = cursorWrData;
    sel = {targetSelectHigh, targetSelectLow};

    // the pins run on other clocks; a level counts only when two
    // stages agree, so a one-cycle glitch never makes an edge
    // three-stage pin sampling, agree filter on stages 2 and 3
    s_d.sync1 = {horizontalDrive, verticalCursorStrobeN,
                 lineControlBit0, pixelClock};
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < 4; i++) begin
      pinNow[i] = (s_q.sync2[i] == s_q.sync3[i]) ? s_q.sync3[i]
                                                 : s_q.pinLevel[i];
    end
    s_d.pinLevel = pinNow;
    pixRise = pinNow[`PAC_PIN_PIXCLK] & ~s_q.pinLevel[`PAC_PIN_PIXCLK];
    hdriveFall = ~pinNow[`PAC_PIN_HDRIVE]
                 & s_q.pinLevel[`PAC_PIN_HDRIVE];
    vstrobeFall = ~pinNow[`PAC_PIN_VSTROBE]
                  & s_q.pinLevel[`PAC_PIN_VSTROBE];

    // previous levels reset high, so a strobe that is already low
    // when reset ends still counts as one access
    // one access per strobe assertion; both low is ignored
    s_d.palRdPrevN = paletteRdN;
    s_d.palWrPrevN = paletteWrN;
    s_d.curRdPrevN = cursorRdN;
    s_d.curWrPrevN = cursorWrN;
    palRdTake = ~paletteRdN & s_q.palRdPrevN & paletteWrN;
    palWrTake = ~paletteWrN & s_q.palWrPrevN & paletteRdN;
    curRdTake = ~cursorRdN & s_q.curRdPrevN & cursorWrN;
    curWrTake = ~cursorWrN & s_q.curWrPrevN & cursorRdN;

    // colour of the addressed entry, table or overlay
    if (!targetSelectHigh) begin
      entryColour = lutMem[s_q.entryAddr];
    end else if (s_q.entryAddr >= `PAC_OVL_FIRST &&
                 s_q.entryAddr <= `PAC_OVL_LAST) begin
      entryColour = overlayMem[ovlWaddr];
    end else begin
      entryColour = 24'h000000; // reserved entry reads zero
    end
    case (s_q.compCount)
      `PAC_COMP_RED: compByte = entryColour[23:16];
      `PAC_COMP_GREEN: compByte = entryColour[15:8];
      default: compByte = entryColour[7:0];
    endcase

    // ---------------- palette data port ----------------
    // bit 8 picks address or colour data, bit 9 table or overlay
    if (palWrTake) begin
      if (!targetSelectLow) begin
        s_d.entryAddr = paletteWrData;
        s_d.compCount = `PAC_COMP_RED;
      end else begin
        case (s_q.compCount)
          `PAC_COMP_RED: begin
            s_d.redHold = paletteWrData;
            s_d.compCount = `PAC_COMP_GREEN;
          end
          `PAC_COMP_GREEN: begin
            s_d.greenHold = paletteWrData;
            s_d.compCount = `PAC_COMP_BLUE;
          end
          default: begin
            // blue: store entry, bump full address
            if (!targetSelectHigh) begin
              lutWe = 1'b1;
            end else if (s_q.entryAddr >= `PAC_OVL_FIRST &&
                         s_q.entryAddr <= `PAC_OVL_LAST) begin
              ovlWe = 1'b1;
            end
            s_d.compCount = `PAC_COMP_RED;
            s_d.entryAddr = s_q.entryAddr + 8'h01;
          end
        endcase
      end
    end else if (palRdTake) begin
      if (!targetSelectLow) begin
        s_d.palRdData = s_q.entryAddr;
      end else begin
        s_d.palRdData = compByte;
        if (s_q.compCount == `PAC_COMP_RED) begin
          s_d.compCount = `PAC_COMP_GREEN;
        end else if (s_q.compCount == `PAC_COMP_GREEN) begin
          s_d.compCount = `PAC_COMP_BLUE;
        end else begin
          s_d.compCount = `PAC_COMP_RED;
          s_d.entryAddr = s_q.entryAddr + 8'h01;
        end
      end
    end

    // ---------------- cursor data port ----------------
    // position slots 1 to 12 sit in posRegs at slot minus one
    if (s_q.curPtr[3:0] == `PAC_CTRL_CMD) begin
      ctrlByte = s_q.curCommand;
    end else if (s_q.curPtr[3:0] <= `PAC_CTRL_LAST) begin
      ctrlByte = s_q.posRegs[4'(s_q.curPtr[3:0] - 4'h1)];
    end else begin
      ctrlByte = 8'h00; // unused slots read zero
    end
    if (curWrTake || curRdTake) begin
      case (sel)
        `PAC_SEL_ADDR_LOW: begin
          if (curWrTake) begin
            s_d.curPtr[7:0] = cursorWrData;
          end else begin
            s_d.curRdData = s_q.curPtr[7:0];
          end
        end
        `PAC_SEL_ADDR_HIGH: begin
          if (curWrTake) begin
            s_d.curPtr[15:8] = cursorWrData;
          end else begin
            s_d.curRdData = s_q.curPtr[15:8];
          end
        end
        `PAC_SEL_RAM: begin
          if (curWrTake) begin
            patWe = 1'b1;
          end else begin
            s_d.curRdData = patternMem[s_q.curPtr[8:0]];
          end
          if (s_q.curPtr[8:0] == `PAC_PTR_BURST_END) begin
            s_d.curPtr = 16'h0000;
          end else begin
            s_d.curPtr[8:0] = s_q.curPtr[8:0] + 9'h001;
          end
        end
        default: begin
          if (curWrTake) begin
            if (s_q.curPtr[3:0] == `PAC_CTRL_CMD) begin
              s_d.curCommand = cursorWrData;
            end else if (s_q.curPtr[3:0] <= `PAC_CTRL_LAST) begin
              s_d.posRegs[4'(s_q.curPtr[3:0] - 4'h1)] =
                cursorWrData;
            end
          end else begin
            s_d.curRdData = ctrlByte;
          end
          if (curWrTake && s_q.curPtr[8:0] == `PAC_PTR_BURST_END) begin
            s_d.curPtr = 16'h0000;
          end else begin
            s_d.curPtr[8:0] = s_q.curPtr[8:0] + 9'h001;
          end
        end
      endcase
    end

    // ---------------- beam position counters ----------------
    // column count held at zero while the strobe is low
    // line count waits for two pixel rises after the strobe falls
    s_d.hStrobe = pinNow[`PAC_PIN_HSTROBE];
    if (!pinNow[`PAC_PIN_HSTROBE]) begin
      s_d.hCount = 12'h000;
    end else if (pixRise) begin
      s_d.hCount = s_q.hCount + 12'h001;
    end
    if (vstrobeFall) begin
      s_d.vArm = 2'h0;
      s_d.vWait = 1'b1;
    end else begin
      if (pixRise && s_q.vWait && s_q.vArm != `PAC_VARM_MIN) begin
        s_d.vArm = s_q.vArm + 2'h1;
      end
      if (hdriveFall) begin
        if (s_q.vWait && s_q.vArm == `PAC_VARM_MIN) begin
          s_d.vCount = 12'h000;
          s_d.vWait = 1'b0;
        end else if (!s_q.vWait) begin
          s_d.vCount = s_q.vCount + 12'h001;
        end
      end
    end

    // ---------------- cursor pixel generation ----------------
    // offsets are signed 14 bits so a cursor near an edge gives
    // negative offsets instead of wrapping into the far side
    cx = {s_q.posRegs[`PAC_CTRL_CX][3:0], s_q.posRegs[`PAC_CTRL_CX - 1]};
    cy = {s_q.posRegs[`PAC_CTRL_CY][3:0], s_q.posRegs[`PAC_CTRL_CY - 1]};
    wx = {s_q.posRegs[`PAC_CTRL_WX][3:0], s_q.posRegs[`PAC_CTRL_WX - 1]};
    wy = {s_q.posRegs[`PAC_CTRL_WY][3:0], s_q.posRegs[`PAC_CTRL_WY - 1]};
    ww = {s_q.posRegs[`PAC_CTRL_WW][3:0], s_q.posRegs[`PAC_CTRL_WW - 1]};
    wh = {s_q.posRegs[`PAC_CTRL_WH][3:0], s_q.posRegs[`PAC_CTRL_WH - 1]};
    dx = $signed({2'b00, s_q.hCount}) - $signed({2'b00, cx});
    dy = $signed({2'b00, s_q.vCount}) - $signed({2'b00, cy});
    col = dx + `PAC_PAT_CENTRE;
    row = dy + `PAC_PAT_CENTRE;
    patIn = col >= 14'sd0 && col <= `PAC_PAT_LAST &&
            row >= 14'sd0 && row <= `PAC_PAT_LAST;
    patByte = patternMem[{row[5:0], col[5:3]}];
    patBit = patIn & patByte[3'(3'h7 - col[2:0])]
             & s_q.curCommand[`PAC_CMD_PAT_EN];
    half = $signed({12'h000, s_q.curCommand[1:0]});
    inWin = {1'b0, s_q.hCount} >= {1'b0, wx} &&
            {1'b0, s_q.hCount} < 13'({1'b0, wx} + {1'b0, ww}) &&
            {1'b0, s_q.vCount} >= {1'b0, wy} &&
            {1'b0, s_q.vCount} < 13'({1'b0, wy} + {1'b0, wh});
    hairBit = inWin & s_q.curCommand[`PAC_CMD_HAIR_EN] &
              ((dx <= half && dx >= -half) ||
               (dy <= half && dy >= -half));
    if (s_q.curCommand[`PAC_CMD_OR_MODE]) begin
      cursorOn = patBit | hairBit;
    end else begin
      cursorOn = patBit ^ hairBit;
    end
    s_d.overlayActive = cursorOn;
    if (cursorOn) begin
      s_d.pixelRgb = overlayMem[0];
    end else begin
      s_d.pixelRgb = lutMem[pixelIndex];
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // reset loads constants only; strobe history starts high
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.palRdPrevN <= 1'b1;
      s_q.palWrPrevN <= 1'b1;
      s_q.curRdPrevN <= 1'b1;
      s_q.curWrPrevN <= 1'b1;
      s_q.curCommand <= `PAC_CMD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // memory writes, no reset on storage
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (lutWe) begin
      lutMem[lutWaddr] <= colourWdata;
    end
    if (ovlWe) begin
      overlayMem[ovlWaddr] <= colourWdata;
    end
    if (patWe) begin
      patternMem[patWaddr] <= patWdata;
    end
  end

  // ------------------------------------------------------------
  // outputs straight from flip-flops
  // ------------------------------------------------------------
  // no logic between the state flops and the pins
  assign paletteRdData = s_q.palRdData;
  assign cursorRdData = s_q.curRdData;
  assign horizontalCursorStrobe = s_q.hStrobe;
  assign overlayActive = s_q.overlayActive;
  assign pixelRgb = s_q.pixelRgb;

endmodule

// ==== bench/pac_proc_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// signal processor model driving the two i/o data ports
// ------------------------------------------------------------
module pac_proc_model (
  input wire logic core_clk,
  input wire logic [7:0] paletteRdData,
  input wire logic [7:0] cursorRdData,
  output logic targetSelectLow,
  output logic targetSelectHigh,
  output logic paletteRdN,
  output logic paletteWrN,
  output logic [7:0] paletteWrData,
  output logic cursorRdN,
  output logic cursorWrN,
  output logic [7:0] cursorWrData
);
  // idle bus: strobes high, selects clear
  initial begin
    {targetSelectHigh, targetSelectLow} = 2'h0;
    {paletteRdN, paletteWrN, cursorRdN, cursorWrN} = 4'hf;
    paletteWrData = 8'h00;
    cursorWrData = 8'h00;
  end

  // select bits {bit 9, bit 8}
  task automatic setSel(input logic [1:0] s);
    @(posedge core_clk);
    {targetSelectHigh, targetSelectLow} <= s;
  endtask

  // one strobe pulse, never both strobes low
  task automatic access(input logic cur, input logic wr,
                        input logic [7:0] wd, output logic [7:0] rd);
    @(posedge core_clk);
    if (cur) begin
      cursorWrData <= wd;
      {cursorRdN, cursorWrN} <= {wr, !wr};
    end else begin
      paletteWrData <= wd;
      {paletteRdN, paletteWrN} <= {wr, !wr};
    end
    // taken at this edge: release, scramble the data lines
    @(posedge core_clk);
    {paletteRdN, paletteWrN, cursorRdN, cursorWrN} <= 4'hf;
    paletteWrData <= ~wd;
    cursorWrData <= ~wd;
    @(negedge core_clk);
    rd = cur ? cursorRdData : paletteRdData;
  endtask
endmodule

// ==== bench/pac_access_chk.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// port checker for the access block
// ------------------------------------------------------------
module pac_access_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic targetSelectLow,
  input wire logic targetSelectHigh,
  input wire logic paletteRdN,
  input wire logic paletteWrN,
  input wire logic [7:0] paletteWrData,
  input wire logic [7:0] paletteRdData,
  input wire logic cursorRdN,
  input wire logic cursorWrN,
  input wire logic [7:0] cursorWrData,
  input wire logic [7:0] cursorRdData,
  input wire logic lineControlBit0,
  input wire logic horizontalCursorStrobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic [3:0] prevN_q; // previous strobe levels
  logic [7:0] palAddr_q, lo_q, hi_q; // last address writes
  logic palOk_q, loOk_q, hiOk_q; // shadows still current
  wire [1:0] sel = {targetSelectHigh, targetSelectLow};
  wire palRd = !paletteRdN && prevN_q[3] && paletteWrN;
  wire palWr = !paletteWrN && prevN_q[2] && paletteRdN;
  wire curRd = !cursorRdN && prevN_q[1] && cursorWrN;
  wire curWr = !cursorWrN && prevN_q[0] && cursorRdN;

  // shadow of address writes, dropped by data accesses
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prevN_q <= 4'hf;
      {palOk_q, loOk_q, hiOk_q} <= 3'h0;
    end else begin
      prevN_q <= {paletteRdN, paletteWrN, cursorRdN, cursorWrN};
      if (palWr && !targetSelectLow) begin
        {palAddr_q, palOk_q} <= {paletteWrData, 1'b1};
      end else if ((palWr || palRd) && targetSelectLow) begin
        palOk_q <= 1'b0;
      end
      if (curWr && sel == 2'h0) begin
        {lo_q, loOk_q} <= {cursorWrData, 1'b1};
      end
      if (curWr && sel == 2'h1) begin
        {hi_q, hiOk_q} <= {cursorWrData, 1'b1};
      end
      if ((curWr || curRd) && sel[1]) begin
        {loOk_q, hiOk_q} <= 2'h0;
      end
    end
  end

  chk_pal_rd_stands: assert property (
    $changed(paletteRdData) |-> $past(palRd))
    else $error("palette read data moved without a read");
  chk_cur_rd_stands: assert property (
    $changed(cursorRdData) |-> $past(curRd))
    else $error("cursor read data moved without a read");
  chk_both_low_idle: assert property (
    (!cursorRdN && !cursorWrN) |=> $stable(cursorRdData))
    else $error("both cursor strobes low changed data");
  chk_pal_addr_back: assert property (
    palRd && !targetSelectLow && palOk_q |=> paletteRdData == palAddr_q)
    else $error("palette address readback wrong");
  chk_ptr_lo_back: assert property (
    curRd && sel == 2'h0 && loOk_q |=> cursorRdData == lo_q)
    else $error("pointer low readback wrong");
  chk_ptr_hi_back: assert property (
    curRd && sel == 2'h1 && hiOk_q |=> cursorRdData == hi_q)
    else $error("pointer high readback wrong");
  chk_hstrobe_high: assert property (
    lineControlBit0 [*6] |-> horizontalCursorStrobe)
    else $error("cursor strobe not high");
  chk_hstrobe_low: assert property (
    !lineControlBit0 [*6] |-> !horizontalCursorStrobe)
    else $error("cursor strobe not low");

  cover property (palRd && targetSelectLow);
  cover property (curWr && sel == 2'h2);
  cover property (curRd && sel == 2'h3);
endmodule

bind pac_access_top pac_access_chk u_pac_access_chk (
  .core_clk, .resetn, .targetSelectLow, .targetSelectHigh,
  .paletteRdN, .paletteWrN, .paletteWrData, .paletteRdData,
  .cursorRdN, .cursorWrN, .cursorWrData, .cursorRdData,
  .lineControlBit0, .horizontalCursorStrobe
);

// ==== bench/pac_access_top_bench.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// bench for the palette and cursor access block
// ------------------------------------------------------------
module pac_access_top_bench;
  logic core_clk, resetn, lineControlBit0;
  logic pixelClock, verticalCursorStrobeN, horizontalDrive;
  logic targetSelectLow, targetSelectHigh;
  logic paletteRdN, paletteWrN, cursorRdN, cursorWrN;
  logic [7:0] paletteWrData, paletteRdData, cursorWrData, cursorRdData;
  logic horizontalCursorStrobe, overlayActive;
  logic [23:0] pixelRgb;
  int errCount = 0;
  int checkCount = 0;

  // image pixel fixed at entry 0; video pins idle while loading
  pac_access_top u_pac_access_top (
    .core_clk, .resetn, .targetSelectLow, .targetSelectHigh,
    .paletteRdN, .paletteWrN, .paletteWrData, .paletteRdData,
    .cursorRdN, .cursorWrN, .cursorWrData, .cursorRdData,
    .pixelClock, .lineControlBit0, .verticalCursorStrobeN,
    .horizontalDrive, .pixelIndex(8'h00), .horizontalCursorStrobe,
    .overlayActive, .pixelRgb
  );

  pac_proc_model u_pac_proc_model (
    .core_clk, .paletteRdData, .cursorRdData, .targetSelectLow,
    .targetSelectHigh, .paletteRdN, .paletteWrN, .paletteWrData,
    .cursorRdN, .cursorWrN, .cursorWrData
  );

  // compare and count
  task automatic check(input string nm, input logic [23:0] seen,
                       input logic [23:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic sel(input logic [1:0] s);
    u_pac_proc_model.setSel(s);
  endtask

  task automatic wr(input logic cur, input logic [7:0] d);
    logic [7:0] unused;
    u_pac_proc_model.access(cur, 1'b1, d, unused);
  endtask

  task automatic rdChk(input logic cur, input logic [7:0] exp,
                       input string nm);
    logic [7:0] d;
    u_pac_proc_model.access(cur, 1'b0, 8'h00, d);
    check(nm, {16'h0000, d}, {16'h0000, exp});
  endtask

  // load both cursor address registers
  task automatic setPtr(input logic [15:0] p);
    sel(2'h0);
    wr(1'b1, p[7:0]);
    sel(2'h1);
    wr(1'b1, p[15:8]);
  endtask

  // cross hair setup: command, cursor x/y, window x/y, width, height
  localparam logic [103:0] hairCfg = {8'h20, 8'h05, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h0f, 8'hff, 8'h0f};

  // one pin period, four core clocks high, seven low: pixel clock or
  // horizontal drive; waits out the three-flop filter before return
  task automatic pinPulse(input bit hd);
    @(posedge core_clk) {horizontalDrive, pixelClock} <= hd ? 2'h2 : 2'h1;
    repeat (3) @(posedge core_clk);
    @(posedge core_clk) {horizontalDrive, pixelClock} <= 2'h0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // verdict and end of run
  task automatic reportAndStop;
    if (errCount == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // 25 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // hang guard, well beyond the sequence length
  initial begin
    #200000;
    errCount++;
    reportAndStop();
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    lineControlBit0 = 1'b0;
    {pixelClock, horizontalDrive, verticalCursorStrobeN} = 3'h1;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    // palette address register
    sel(2'h0);
    wr(1'b0, 8'h5a);
    rdChk(1'b0, 8'h5a, "pal addr");
    // two entries across the top of the table
    wr(1'b0, 8'hff);
    sel(2'h1);
    for (int i = 0; i < 6; i++) wr(1'b0, 8'h10 + 8'(i));
    sel(2'h0);
    rdChk(1'b0, 8'h01, "pal wr inc");
    wr(1'b0, 8'hff);
    sel(2'h1);
    for (int i = 0; i < 6; i++)
      rdChk(1'b0, 8'h10 + 8'(i), "rgb");
    sel(2'h0);
    rdChk(1'b0, 8'h01, "pal rd inc");
    check("pixel", pixelRgb, 24'h131415);
    // overlay colours, then read from reserved entry up
    for (int i = 1; i < 4; i++) begin
      sel(2'h2);
      wr(1'b0, 8'(i));
      sel(2'h3);
      for (int c = 0; c < 3; c++) wr(1'b0, 8'(16 * i + c));
    end
    sel(2'h2);
    wr(1'b0, 8'h00);
    sel(2'h3);
    for (int i = 0; i < 12; i++)
      rdChk(1'b0, 8'(i < 3 ? 0 : 16 * (i / 3) + i % 3), "ovl");
    // pointer registers and ram burst over the wrap
    setPtr(16'h01fe);
    sel(2'h0);
    rdChk(1'b1, 8'hfe, "ptr lo");
    rdChk(1'b1, 8'hfe, "ptr lo again");
    sel(2'h1);
    rdChk(1'b1, 8'h01, "ptr hi");
    sel(2'h2);
    wr(1'b1, 8'ha1);
    wr(1'b1, 8'hb2);
    wr(1'b1, 8'hc3);
    sel(2'h0);
    rdChk(1'b1, 8'h01, "wrap lo");
    sel(2'h1);
    rdChk(1'b1, 8'h00, "wrap hi");
    setPtr(16'h01fe);
    sel(2'h2);
    rdChk(1'b1, 8'ha1, "ram 1fe");
    rdChk(1'b1, 8'hb2, "ram 1ff");
    rdChk(1'b1, 8'hc3, "ram 000");
    // control registers: command 1:1, or mode, 7 pixels
    setPtr(16'h0000);
    sel(2'h3);
    for (int i = 0; i < 13; i++)
      wr(1'b1, 8'(i == 0 ? 'h13 : i));
    setPtr(16'h0000);
    sel(2'h3);
    for (int i = 0; i < 13; i++)
      rdChk(1'b1, 8'(i == 0 ? 'h13 : i), "ctrl");
    sel(2'h0);
    rdChk(1'b1, 8'h0d, "ctrl inc");
    // control wrap: read keeps upper bits, write clears all
    setPtr(16'h03ff);
    sel(2'h3);
    rdChk(1'b1, 8'h00, "ctrl spare");
    sel(2'h1);
    rdChk(1'b1, 8'h02, "rd wrap hi");
    setPtr(16'h03ff);
    sel(2'h3);
    wr(1'b1, 8'h55);
    sel(2'h1);
    rdChk(1'b1, 8'h00, "wr wrap hi");
    // horizontal cursor strobe follows line control bit
    @(posedge core_clk) lineControlBit0 <= 1'b1;
    repeat (8) @(negedge core_clk);
    check("hstrobe hi", {23'h0, horizontalCursorStrobe}, 24'h1);
    @(posedge core_clk) lineControlBit0 <= 1'b0;
    repeat (8) @(negedge core_clk);
    check("hstrobe lo", {23'h0, horizontalCursorStrobe}, 24'h0);
    // cross hair one pixel wide at column 5, row 1, full screen
    setPtr(16'h0000);
    sel(2'h3);
    for (int i = 0; i < 13; i++)
      wr(1'b1, hairCfg[103 - 8 * i -: 8]);
    @(posedge core_clk) lineControlBit0 <= 1'b1;
    repeat (8) @(negedge core_clk);
    check("hair off", {23'h0, overlayActive}, 24'h0);
    check("image px", pixelRgb, 24'h131415);
    repeat (5) pinPulse(1'b0);
    check("hair col", {23'h0, overlayActive}, 24'h1);
    check("ovl px", pixelRgb, 24'h101112);
    pinPulse(1'b0);
    check("hair past", {23'h0, overlayActive}, 24'h0);
    // lines count on drive falls, restart two pixels after strobe
    pinPulse(1'b1);
    check("row 1", {23'h0, overlayActive}, 24'h1);
    @(posedge core_clk) verticalCursorStrobeN <= 1'b0;
    pinPulse(1'b1);
    check("row early", {23'h0, overlayActive}, 24'h1);
    repeat (2) pinPulse(1'b0);
    pinPulse(1'b1);
    check("row 0", {23'h0, overlayActive}, 24'h0);
    pinPulse(1'b1);
    check("row 1 again", {23'h0, overlayActive}, 24'h1);
    reportAndStop();
  end
endmodule
